// ==== memory_scan_range_trigger.sv ====
/*
 * Memory scan address range and trigger control with APB registers.
 * Assumes a program memory that answers a fetch request with one
 * valid pulse, and a CRC engine that signals ready for new data.
 */
// Implementation choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
`include "scan_params.svh"

// Operation
// (R1) Current address is 16 bits from two bytes, incremented per fetch.
// (R2) Writes to address bytes are ignored while the run bit is set.
// (R3) Software touches address pairs only while the run bit is clear.
// (R4) End address is 16 bits from high and low byte registers.
// (R5) Four-bit trigger select; codes 0,8,9 defined, 10 to 15 reserved.
// (R6) Codes 1-3 pick timer postscalers, 4-7 pick timer overflows.
// (R7) Upper four trigger select bits read zero and ignore writes.
// (R8) Run bit clears once current exceeds end with no data cycle.
// (R9) Two-bit mode: concurrent, burst, peek, triggered.
// (R10) Invalid flag when address passes or lies outside program memory.
// (R11) Clearing enable resets the state machine, other registers kept.
// (R12) In triggered mode each trigger edge allows exactly one fetch.
module memory_scan_range_trigger (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        low_freq_internal_osc,
    input  wire logic        timer2_postscale_out,
    input  wire logic        timer4_postscale_out,
    input  wire logic        timer6_postscale_out,
    input  wire logic        timer1_overflow,
    input  wire logic        timer3_overflow,
    input  wire logic        timer5_overflow,
    input  wire logic        timer0_overflow,
    input  wire logic        measure_timer1_match,
    input  wire logic        measure_timer2_match,
    input  wire logic        cpu_in_interrupt,
    output logic             mem_req,
    output logic      [15:0] mem_addr,
    input  wire logic        mem_valid,
    input  wire logic [13:0] mem_data,
    input  wire logic        crc_ready,
    output logic             crc_valid,
    output logic      [15:0] crc_data,
    output logic             cpu_stall,
    output logic             irq
);
    scan_fetch_if fi ();

    // Control and address registers
    logic        enable_r;
    logic        run_r;
    logic        hold_mode_r;
    logic [1:0]  mode_r;
    logic [15:0] cur_r;
    logic [15:0] end_r;
    logic [3:0]  trig_r;
    logic [1:0]  irq_status_r;
    logic [1:0]  irq_mask_r;
    logic        pending_r;
    scan_pkg::scan_state_type state_r;
    scan_pkg::scan_state_type state_nxt;

    logic [9:0]  src_raw;
    logic [9:0]  src_sync;
    logic        cpu_int_sync;

    // Route trigger sources by code order
    assign src_raw = {measure_timer2_match, measure_timer1_match,
                      timer0_overflow, timer5_overflow, timer3_overflow,
                      timer1_overflow, timer6_postscale_out,
                      timer4_postscale_out, timer2_postscale_out,
                      low_freq_internal_osc}; // (R5) (R6)

    // Pins cross into pclk through two flops before any use
    scan_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .async_in (src_raw),
        .sync_out (src_sync)
    );

    assign fi.source_code = trig_r;
    assign fi.sources     = src_sync;

    // Rising edge of the selected source arms one fetch
    scan_trigger_sel u_trig (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .fi      (fi.sel)
    );

    // Interrupt level comes from the core clock domain
    assign cpu_int_sync = cpu_in_interrupt;

    // APB decode
    logic wr_en;
    logic rd_en;
    logic hit;
    logic addr_lock;
    assign wr_en = psel & penable & pwrite & ce;
    assign rd_en = psel & ~pwrite;
    assign pready = 1'b1;
    // One match line per mapped register offset
    localparam logic [11:0] reg_ofs [8] = '{
        `OFS_CONTROL,
        `OFS_CUR_LO,
        `OFS_CUR_HI,
        `OFS_END_LO,
        `OFS_END_HI,
        `OFS_TRIG,
        `OFS_IRQ_STATUS,
        `OFS_IRQ_MASK
    };
    logic [7:0] hit_vec;
    for (genvar gi = 0; gi < 8; gi++) begin : g_hit
        assign hit_vec[gi] = (paddr == reg_ofs[gi]);
    end
    assign hit = |hit_vec;
    assign pslverr = psel & penable & ~hit;
    assign addr_lock = run_r; // (R2)

    function automatic logic wr_at(input logic [11:0] ofs);
        wr_at = wr_en && (paddr == ofs);
    endfunction

    // Write strobes for continuous logic; keeps their sensitivity explicit
    logic wr_ctl;
    logic wr_irq_st;
    assign wr_ctl    = wr_en & (paddr == `OFS_CONTROL);
    assign wr_irq_st = wr_en & (paddr == `OFS_IRQ_STATUS);

    // Address state
    logic [16:0] cur_ext;
    logic        past_end;
    logic        invalid;
    logic        busy;
    logic        go_eff;
    logic        mode_ok;
    logic        fetch_done;
    assign cur_ext  = {1'b0, cur_r};
    assign past_end = cur_r > end_r; // (R8)
    assign invalid  = cur_ext >= `PROG_MEM_WORDS; // (R10)
    // Busy also shows the engine's ready, as software expects
    assign busy     = (state_r != scan_pkg::ST_IDLE) | crc_ready;
    // Interrupt hold gates the run bit except in peek mode
    assign go_eff   = run_r & enable_r & ~invalid &
                      ~(hold_mode_r & cpu_int_sync &
                        (mode_r != 2'(scan_pkg::MODE_PEEK)));
    // A fetch ends when memory answers in the fetch state
    assign fetch_done = (state_r == scan_pkg::ST_FETCH) & mem_valid;

    // Mode decides whether a fetch may begin
    always_comb begin
        case (scan_pkg::access_mode_type'(mode_r)) // (R9)
            scan_pkg::MODE_TRIGGERED: mode_ok = pending_r; // (R12)
            scan_pkg::MODE_CONCURRENT: mode_ok = 1'b1;
            scan_pkg::MODE_BURST: mode_ok = 1'b1;
            scan_pkg::MODE_PEEK: mode_ok = 1'b1;
            default: mode_ok = 1'b0;
        endcase
    end

    // Fetch state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            scan_pkg::ST_IDLE: begin
                if (go_eff && !past_end && crc_ready && mode_ok) begin
                    state_nxt = scan_pkg::ST_FETCH;
                end
            end
            scan_pkg::ST_FETCH: begin
                if (mem_valid) begin
                    state_nxt = scan_pkg::ST_HAND;
                end
            end
            scan_pkg::ST_HAND: begin
                state_nxt = scan_pkg::ST_IDLE;
            end
            default: state_nxt = scan_pkg::ST_IDLE;
        endcase
        if (!enable_r) begin
            state_nxt = scan_pkg::ST_IDLE; // (R11)
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= scan_pkg::ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // Triggered mode: one edge arms exactly one fetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_r <= 1'b0;
        end else if (ce) begin
            if (!enable_r || !run_r) begin
                pending_r <= 1'b0; // (R11)
            end else if (fi.trig_event) begin
                pending_r <= 1'b1; // (R12)
            end else if (state_r == scan_pkg::ST_IDLE &&
                         state_nxt == scan_pkg::ST_FETCH) begin
                pending_r <= 1'b0; // (R12)
            end
        end
    end

    // Control register; run bit cleared by hardware at range end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r    <= 1'b0;
            run_r       <= 1'b0;
            hold_mode_r <= 1'b0;
            mode_r      <= `RST_MODE;
        end else if (ce) begin
            if (wr_at(`OFS_CONTROL)) begin
                enable_r    <= pwdata[`CTL_ENABLE_BIT];
                run_r       <= pwdata[`CTL_RUN_BIT];
                hold_mode_r <= pwdata[`CTL_HOLD_BIT];
                mode_r      <= pwdata[`CTL_MODE_HI:`CTL_MODE_LO]; // (R9)
            end else if (run_r && past_end &&
                         state_r == scan_pkg::ST_IDLE) begin
                run_r <= 1'b0; // (R8)
            end
        end
    end

    // Current address: bytes writable only while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_r <= {`RST_BYTE, `RST_BYTE};
        end else if (ce) begin
            if (fetch_done) begin
                cur_r <= cur_r + 16'h0001; // (R1)
            end else if (!addr_lock) begin // (R2)
                if (wr_at(`OFS_CUR_LO)) begin
                    cur_r[7:0] <= pwdata[7:0]; // (R1)
                end
                if (wr_at(`OFS_CUR_HI)) begin
                    cur_r[15:8] <= pwdata[7:0]; // (R1)
                end
            end
        end
    end

    // End address and trigger select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            end_r  <= {`RST_BYTE, `RST_BYTE};
            trig_r <= `RST_TRIG;
        end else if (ce) begin
            if (!addr_lock && wr_at(`OFS_END_LO)) begin // (R2)
                end_r[7:0] <= pwdata[7:0]; // (R4)
            end
            if (!addr_lock && wr_at(`OFS_END_HI)) begin // (R2)
                end_r[15:8] <= pwdata[7:0]; // (R4)
            end
            if (wr_at(`OFS_TRIG)) begin
                trig_r <= pwdata[3:0]; // (R7)
            end
        end
    end

    // Interrupt status: set wins over write-one-to-clear
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    assign irq_set[`IRQ_DONE_BIT]    = run_r & past_end &
                                       (state_r == scan_pkg::ST_IDLE) &
                                       ~wr_ctl;
    assign irq_set[`IRQ_INVALID_BIT] = fetch_done &
                                       (cur_ext + 17'h00001 >=
                                        `PROG_MEM_WORDS);
    assign irq_clr = wr_irq_st ? pwdata[1:0] : 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= `RST_IRQ;
            irq_mask_r   <= `RST_IRQ;
        end else if (ce) begin
            irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
            if (wr_at(`OFS_IRQ_MASK)) begin
                irq_mask_r <= pwdata[1:0];
            end
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign irq = |(irq_status_r & irq_mask_r);

    // Data outputs from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_valid <= 1'b0;
            crc_data  <= 16'h0000;
        end else if (ce) begin
            crc_valid <= fetch_done;
            if (fetch_done) begin
                crc_data <= {2'h0, mem_data};
            end
        end
    end

    // Request follows the state; address is the live register
    assign mem_req  = (state_r == scan_pkg::ST_FETCH);
    assign mem_addr = cur_r;
    assign cpu_stall = go_eff & ~past_end &
                       (mode_r == 2'(scan_pkg::MODE_BURST)); // (R9)

    // Read mux
    logic [7:0] ctl_rd;
    assign ctl_rd = {enable_r, run_r, busy, invalid, hold_mode_r, 1'b0,
                     mode_r};
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `OFS_CONTROL:    prdata = {24'h0, ctl_rd};
                `OFS_CUR_LO:     prdata = {24'h0, cur_r[7:0]};
                `OFS_CUR_HI:     prdata = {24'h0, cur_r[15:8]};
                `OFS_END_LO:     prdata = {24'h0, end_r[7:0]};
                `OFS_END_HI:     prdata = {24'h0, end_r[15:8]};
                `OFS_TRIG:       prdata = {28'h0, trig_r}; // (R7)
                `OFS_IRQ_STATUS: prdata = {30'h0, irq_status_r};
                `OFS_IRQ_MASK:   prdata = {30'h0, irq_mask_r};
                default:         prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // memory_scan_range_trigger
`default_nettype wire

// ==== scan_params.svh ====
/*
 * Constants for the memory scan range and trigger block: register
 * offsets, field positions, reset values and memory limits.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SCAN_PARAMS_SVH
`define SCAN_PARAMS_SVH

// Register byte offsets on APB
`define OFS_CONTROL        12'h000
`define OFS_CUR_LO         12'h004
`define OFS_CUR_HI         12'h008
`define OFS_END_LO         12'h00c
`define OFS_END_HI         12'h010
`define OFS_TRIG           12'h014
`define OFS_IRQ_STATUS     12'h018
`define OFS_IRQ_MASK       12'h01c

// Control register field positions
`define CTL_ENABLE_BIT     7
`define CTL_RUN_BIT        6
`define CTL_BUSY_BIT       5
`define CTL_INVALID_BIT    4
`define CTL_HOLD_BIT       3
`define CTL_MODE_HI        1
`define CTL_MODE_LO        0

// Interrupt status bit positions
`define IRQ_DONE_BIT       0
`define IRQ_INVALID_BIT    1

// Reset values
`define RST_BYTE           8'h00
`define RST_TRIG           4'h0
`define RST_MODE           2'h0
`define RST_IRQ            2'h0

// Program memory holds this many words
`define PROG_MEM_WORDS     17'h04000

`endif

// ==== scan_pkg.sv ====
/*
 * Types shared by the scan block modules.
 * Assumes scan_params.svh is available for constants.
 */
`default_nettype none
package scan_pkg;
    typedef enum logic [1:0] {
        MODE_CONCURRENT,
        MODE_BURST,
        MODE_PEEK,
        MODE_TRIGGERED
    } access_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_HAND
    } scan_state_type;
endpackage
`default_nettype wire

// ==== scan_fetch_if.sv ====
/*
 * Interface between the scan control and its trigger selector.
 * Assumes both ends run on pclk.
 */
`default_nettype none
interface scan_fetch_if;
    logic [3:0] source_code;
    logic [9:0] sources;
    logic       trig_event;

    modport ctrl (output source_code, output sources, input trig_event);
    modport sel  (input source_code, input sources, output trig_event);
endinterface
`default_nettype wire

// ==== scan_trigger_sel.sv ====
/*
 * Trigger selector: picks one source by code and makes a one-cycle
 * pulse on its rising edge. Assumes sources are already synchronised.
 */
`default_nettype none
`include "scan_params.svh"
module scan_trigger_sel (
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   ce,
    scan_fetch_if.sel   fi
);
    logic picked;
    logic picked_r;

    // Codes 0..9 pick a source, the reserved codes pick nothing
    assign picked = (fi.source_code <= 4'h9) ?
                    fi.sources[fi.source_code] : 1'b0; // (R5) (R6)

    // Remember the last level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            picked_r <= 1'b0;
        end else if (ce) begin
            picked_r <= picked;
        end
    end

    assign fi.trig_event = ce & picked & ~picked_r; // (R12)
endmodule // scan_trigger_sel

// ==== scan_sync.sv ====
/*
 * Two-flip-flop synchroniser for a bus of pin-level inputs.
 * Assumes inputs are asynchronous to pclk.
 */
`default_nettype none
module scan_sync (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic [9:0]  async_in,
    output logic      [9:0]  sync_out
);
    logic [9:0] meta_r;

    // First stage is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r   <= 10'h000;
            sync_out <= 10'h000;
        end else if (ce) begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // scan_sync

// ==== scan_range_monitor.sv ====
/* Port checker for the scan range block: fetch handshake, address
   stepping and register read-back.
   Assumes it is bound into memory_scan_range_trigger. */
`default_nettype none
`include "scan_params.svh"
module scan_range_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_valid,
    input wire logic        crc_ready,
    input wire logic        crc_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Decoded events: register write, completed fetch, read select
    wire reg_write = psel && penable && pwrite && ce;
    wire fetch_done = mem_req && mem_valid && ce && !reg_write;
    wire rd_sel = psel && !pwrite;

    a_addr_step: assert property (
        fetch_done |=> mem_addr == $past(mem_addr) + 16'h0001)
        else $error("address did not step after a fetch");
    a_addr_hold: assert property (
        !fetch_done && !reg_write |=> $stable(mem_addr))
        else $error("address moved without fetch or write");
    a_word_follows: assert property (
        fetch_done |=> crc_valid)
        else $error("no word handed on after a fetch");
    a_word_pulse: assert property (
        crc_valid |=> !crc_valid)
        else $error("word valid lasted more than one cycle");
    a_req_hold: assert property (
        mem_req && !mem_valid && !reg_write |=> mem_req && $stable(mem_addr))
        else $error("fetch request dropped before data");
    a_req_ready: assert property (
        $rose(mem_req) |-> $past(crc_ready))
        else $error("fetch started while engine not ready");
    a_req_inside: assert property (
        mem_req |-> mem_addr < 16'h4000)
        else $error("fetch outside program memory");
    a_trig_upper: assert property (
        rd_sel && paddr == `OFS_TRIG |-> prdata[31:4] == 28'h0)
        else $error("trigger select upper bits not zero");
    a_cur_lo_read: assert property (
        rd_sel && paddr == `OFS_CUR_LO |-> prdata == {24'h0, mem_addr[7:0]})
        else $error("current low byte read mismatch");
    a_cur_hi_read: assert property (
        rd_sel && paddr == `OFS_CUR_HI |-> prdata == {24'h0, mem_addr[15:8]})
        else $error("current high byte read mismatch");
endmodule // scan_range_monitor

bind memory_scan_range_trigger scan_range_monitor mon_u (.pclk, .presetn,
    .ce, .psel, .penable, .pwrite, .paddr, .prdata, .mem_req, .mem_addr,
    .mem_valid, .crc_ready, .crc_valid);
`default_nettype wire

// ==== scan_far_side.sv ====
/* Far side model: program memory answering fetches, CRC engine taking
   one word per pulse. Assumes the scan block shares pclk. */
`default_nettype none
module scan_far_side (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic             mem_valid,
    output logic      [13:0] mem_data,
    input  wire logic        crc_valid,
    output logic             crc_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_r;
    logic [1:0] gap_r;
    wire  [2:0] delay = slow ? 3'h4 : 3'h0;
    // Memory answers after a delay; data churns while not valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 3'h0;
            mem_valid <= 1'b0;
            mem_data <= 14'h0000;
        end else if (mem_req && !mem_valid && wait_r == delay) begin
            wait_r <= 3'h0;
            mem_valid <= 1'b1;
            mem_data <= mem_addr[13:0] ^ 14'h2a5a;
        end else begin
            wait_r <= (mem_req && !mem_valid) ? wait_r + 3'h1 : 3'h0;
            mem_valid <= 1'b0;
            mem_data <= ~mem_data;
        end
    end
    // Engine stays busy a few cycles after each word when slow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gap_r <= 2'h0;
        else if (crc_valid && slow) gap_r <= 2'h3;
        else if (gap_r != 2'h0) gap_r <= gap_r - 2'h1;
    end
    assign crc_ready = (gap_r == 2'h0);
endmodule // scan_far_side
`default_nettype wire

// ==== memory_scan_range_trigger_bench.sv ====
/* Bench for the scan block: APB tasks, far side model, scans in concurrent,
   burst and triggered mode, every trigger source. Assumes design and model files compiled. */
`default_nettype none
`include "scan_params.svh"
module memory_scan_range_trigger_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic cpu_in_interrupt, slow, mem_req, mem_valid, crc_ready, crc_valid;
    logic cpu_stall, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  src;
    logic [15:0] mem_addr, crc_data, exp_addr;
    logic [13:0] mem_data;
    int failures, cmp_count, fetches, cycles;

    memory_scan_range_trigger dut_u (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cpu_in_interrupt, .mem_req,
        .mem_addr, .mem_valid, .mem_data, .crc_ready, .crc_valid,
        .crc_data, .cpu_stall, .irq,
        .low_freq_internal_osc(src[0]), .timer2_postscale_out(src[1]),
        .timer4_postscale_out(src[2]), .timer6_postscale_out(src[3]),
        .timer1_overflow(src[4]), .timer3_overflow(src[5]),
        .timer5_overflow(src[6]), .timer0_overflow(src[7]),
        .measure_timer1_match(src[8]), .measure_timer2_match(src[9]));
    scan_far_side far_u (.pclk, .presetn, .slow, .mem_req, .mem_addr,
        .mem_valid, .mem_data, .crc_valid, .crc_ready);

    always #5 pclk = ~pclk;

    task automatic print_verdict();
        if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer; answer taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Address pairs written low then high, only while stopped
    task automatic set_range(input logic [15:0] c, input logic [15:0] e);
        apb(1'b1, `OFS_CUR_LO, {24'h0, c[7:0]});
        apb(1'b1, `OFS_CUR_HI, {24'h0, c[15:8]});
        apb(1'b1, `OFS_END_LO, {24'h0, e[7:0]});
        apb(1'b1, `OFS_END_HI, {24'h0, e[15:8]});
        exp_addr = c;
        fetches = 0;
    endtask
    task automatic wait_stop();
        apb(1'b0, `OFS_CONTROL, 32'h0);
        for (int i = 0; i < 100 && rd[6] !== 1'b0; i++)
            apb(1'b0, `OFS_CONTROL, 32'h0);
        // Engine ready settles a few cycles after the last word
        repeat (4) @(posedge pclk);
        apb(1'b0, `OFS_CONTROL, 32'h0);
    endtask
    task automatic pulse(input int i);
        src[i] <= 1'b1;
        repeat (4) @(posedge pclk);
        src[i] <= 1'b0;
        repeat (14) @(posedge pclk);
    endtask

    // Word content check, word count and run-time ceiling
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (crc_valid === 1'b1) begin
            chk({18'h0, crc_data[13:0]}, {18'h0, exp_addr[13:0] ^ 14'h2a5a});
            exp_addr <= exp_addr + 16'h0001;
            fetches <= fetches + 1;
        end
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; cpu_in_interrupt = 0; slow = 0; src = 0;
        failures = 0; cmp_count = 0; fetches = 0; cycles = 0; exp_addr = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, unmapped place, trigger nibble, modes
        for (int a = 4; a < 32; a += 4) begin
            apb(1'b0, a[11:0], 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `OFS_TRIG, 32'hfa);
        apb(1'b0, `OFS_TRIG, 32'h0);
        chk(rd, 32'h0a);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `OFS_CONTROL, 32'h80 | m);
            apb(1'b0, `OFS_CONTROL, 32'h0);
            chk(rd, 32'ha0 | m);
        end
        // Slow concurrent scan across a byte carry, end write mid-run
        slow = 1;
        set_range(16'h00fe, 16'h0101);
        apb(1'b1, `OFS_CONTROL, 32'hc0);
        apb(1'b1, `OFS_END_LO, 32'h07);
        wait_stop();
        chk(rd, 32'ha0);
        chk(fetches, 32'h4);
        apb(1'b0, `OFS_CUR_LO, 32'h0);
        chk(rd, 32'h02);
        apb(1'b0, `OFS_CUR_HI, 32'h0);
        chk(rd, 32'h01);
        apb(1'b0, `OFS_END_LO, 32'h0);
        chk(rd, 32'h01);
        // Done event raises irq only when unmasked
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `OFS_IRQ_MASK, 32'h3);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        // Last word of program memory leaves the address invalid
        set_range(16'h3fff, 16'h3fff);
        apb(1'b1, `OFS_CONTROL, 32'hc0);
        wait_stop();
        chk(rd, 32'hb0);
        chk(fetches, 32'h1);
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, `OFS_IRQ_STATUS, 32'h3);
        // Burst held by interrupt, then enable cleared mid-run
        set_range(16'h0040, 16'h0047);
        cpu_in_interrupt <= 1'b1;
        apb(1'b1, `OFS_CONTROL, 32'hc9);
        repeat (10) @(posedge pclk);
        chk(fetches, 32'h0);
        cpu_in_interrupt <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({31'h0, cpu_stall}, 32'h1);
        for (int i = 0; i < 100 && fetches != 2; i++) @(posedge pclk);
        apb(1'b1, `OFS_CONTROL, 32'h0);
        repeat (20) @(posedge pclk);
        chk(fetches, 32'h2);
        chk({31'h0, cpu_stall}, 32'h0);
        apb(1'b0, `OFS_CUR_LO, 32'h0);
        chk(rd, 32'h42);
        apb(1'b0, `OFS_END_LO, 32'h0);
        chk(rd, 32'h47);
        // Triggered mode: each source, one fetch per rising edge
        for (int k = 0; k < 10; k++) begin
            set_range(16'h0020, 16'h0021);
            apb(1'b1, `OFS_TRIG, k);
            apb(1'b1, `OFS_CONTROL, 32'hc3);
            pulse((k + 1) % 10);
            chk(fetches, 32'h0);
            pulse(k);
            chk(fetches, 32'h1);
            pulse(k);
            apb(1'b0, `OFS_CONTROL, 32'h0);
            chk(rd, 32'ha3);
            chk(fetches, 32'h2);
        end
        print_verdict();
    end
endmodule // memory_scan_range_trigger_bench
`default_nettype wire
